/* File: core/tyag_frame_timer.sv */
// frame counter that measures the one second windows
`timescale 1ns/1ps
`default_nettype none
module tyag_frame_timer
    import tyag_pkg::*;
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             clear,
    input  wire logic             frame_tick,
    input  wire logic [TMR_W-1:0] limit,
    output var  logic [TMR_W-1:0] count,
    output var  logic             done
);
    logic [TMR_W-1:0] cnt_q;
    logic [TMR_W-1:0] cnt_d;
    wire              at_lim = (cnt_q >= limit);

    // ===========================================
    // counting frames keeps the window tied to line time
    assign cnt_d = clear ? '0 :
                   (frame_tick && !at_lim) ? cnt_q + 1'b1 :
                   cnt_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign count = cnt_q;
    assign done  = at_lim && !clear;
endmodule // tyag_frame_timer
`default_nettype wire

/* File: core/tyag_pkg.sv */
// package: constants and types of the t1 yellow alarm generator
`default_nettype none
package tyag_pkg;
    // ===========================================
    // register map
    localparam logic [11:0] AGC_OFF   = 12'h000;
    localparam logic [11:0] FFS_OFF   = 12'h004;
    localparam logic [11:0] STAT_OFF  = 12'h008;
    // ===========================================
    // alarm_generation_control fields
    localparam int RULE_BIT   = 7;
    localparam int REQ_BIT    = 6;
    localparam int FMT_HI     = 5;
    localparam int FMT_LO     = 4;
    localparam logic [7:0] AGC_RST = 8'h00;
    localparam logic [2:0] FFS_RST = 3'h0;
    // ===========================================
    // rai_format_select codes
    localparam logic [1:0] FMT_OFF  = 2'h0;
    localparam logic [1:0] FMT_BIT2 = 2'h1;
    // framing_format_select codes
    localparam logic [2:0] FFS_SF   = 3'h5;
    localparam logic [2:0] FFS_N    = 3'h6;
    // ===========================================
    // timing: one second counted in frames
    localparam int RAI_MIN_MS     = 1000;
    localparam int FRAME_PERIOD_US = 125;
    localparam int FRAMES_PER_SEC =
        RAI_MIN_MS * 1000 / FRAME_PERIOD_US;
    localparam int TMR_W = 13;
    // ===========================================
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SEND,
        ST_GAP
    } tyag_state_e;
endpackage
`default_nettype wire

/* File: core/tyag_top.sv */
// t1 transmit yellow alarm generation with apb registers
`timescale 1ns/1ps
`default_nettype none
// Contract
// - control bit seven enables one-second rule
// - enforced: each alarm lasts at least one second
// - enforced: one second gap between alarms
// - enforced: request bit sets alarm duration
// - enforced: format field picks format, and 00 blocks the request
// - not enforced: no gap between alarms
// - not enforced: format field sets everything
// - not enforced: still one second minimum
// - enforced: request one starts, zero stops
// - not enforced: request bit ignored
// - format 00 disables alarm
// - sf/n format 01 forces bit two zero
module tyag_top
    import tyag_pkg::*;
#(
    parameter int FRAMES_PER_SECOND = FRAMES_PER_SEC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        frame_tick,
    output var  logic        rai_active,
    output var  logic [1:0]  rai_format,
    output var  logic        rai_bit2_force
);
    // ===========================================
    // decode helpers
    function automatic logic reg_hit(
        input logic [11:0] a,
        input logic [11:0] off
    );
        reg_hit = (a == off);
    endfunction

    function automatic logic is_bit2_framing(
        input logic [2:0] f
    );
        is_bit2_framing = (f == FFS_SF) || (f == FFS_N);
    endfunction

    // ===========================================
    // state
    logic [7:0]       agc_q;
    logic [7:0]       agc_d;
    logic [2:0]       ffs_q;
    logic [2:0]       ffs_d;
    logic [31:0]      prdata_q;
    logic [31:0]      prdata_d;
    logic             pready_q;
    logic             pready_d;
    logic             pslverr_q;
    logic             pslverr_d;
    tyag_state_e      state_q;
    tyag_state_e      state_d;
    logic [1:0]       fmt_q;
    logic [1:0]       fmt_d;
    logic             active_q;
    logic             bit2_q;
    logic             bit2_d;
    logic [1:0]       tmr_clear;
    logic [1:0]       tmr_done;
    logic [TMR_W-1:0] tmr_cnt [2];

    wire [TMR_W-1:0] limit = FRAMES_PER_SECOND[TMR_W-1:0];

    // ===========================================
    // apb decode
    wire acc      = psel && penable;
    wire commit   = acc && pready_q;
    wire hit_agc  = reg_hit(paddr, AGC_OFF);
    wire hit_ffs  = reg_hit(paddr, FFS_OFF);
    wire hit_stat = reg_hit(paddr, STAT_OFF);
    wire mapped   = hit_agc || hit_ffs || hit_stat;
    wire wr_agc   = commit && pwrite && hit_agc;
    wire wr_ffs   = commit && pwrite && hit_ffs;

    // one wait state: answer on second access cycle
    assign pready_d  = acc && !pready_q;
    assign pslverr_d = pready_d && !mapped;

    wire [31:0] stat_word = {
        28'h0000000,
        fmt_q,
        (state_q == ST_GAP),
        active_q
    };

    assign prdata_d =
        !(pready_d && !pwrite) ? 32'h00000000 :
        hit_agc  ? {24'h000000, agc_q} :
        hit_ffs  ? {29'h00000000, ffs_q} :
        hit_stat ? stat_word :
        32'h00000000;

    assign agc_d = wr_agc ? pwdata[7:0] : agc_q;
    assign ffs_d = wr_ffs ? pwdata[2:0] : ffs_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            agc_q     <= AGC_RST;
            ffs_q     <= FFS_RST;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else begin
            agc_q     <= agc_d;
            ffs_q     <= ffs_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q  <= prdata_d;
        end
    end

    // ===========================================
    // alarm control
    wire       rule_en = agc_q[RULE_BIT];
    wire       req     = agc_q[REQ_BIT];
    wire [1:0] fmt_sel = agc_q[FMT_HI:FMT_LO];
    wire       fmt_on  = (fmt_sel != FMT_OFF);

    // enforced: request bit decides duration
    // not enforced: request bit ignored
    wire want = rule_en ? (req && fmt_on) : fmt_on;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (want) begin
                    state_d = ST_SEND;
                end
            end
            ST_SEND: begin
                // the one second floor holds in both modes
                if (!want && tmr_done[0]) begin
                    state_d = rule_en ? ST_GAP : ST_IDLE;
                end
            end
            ST_GAP: begin
                if (!rule_en || tmr_done[1]) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // format tracks the field while wanted, held over the tail
    assign fmt_d  = (state_d == ST_SEND && want) ? fmt_sel :
                    (state_d == ST_SEND) ? fmt_q : FMT_OFF;
    assign bit2_d = (state_d == ST_SEND) && (fmt_d == FMT_BIT2) &&
                    is_bit2_framing(ffs_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q  <= ST_IDLE;
            fmt_q    <= FMT_OFF;
            active_q <= 1'b0;
            bit2_q   <= 1'b0;
        end else begin
            state_q  <= state_d;
            fmt_q    <= fmt_d;
            active_q <= (state_d == ST_SEND);
            bit2_q   <= bit2_d;
        end
    end

    // ===========================================
    // timers: 0 measures the alarm, 1 the gap
    assign tmr_clear[0] = (state_q != ST_SEND);
    assign tmr_clear[1] = (state_q != ST_GAP);

    for (genvar i = 0; i < 2; i++) begin : g_tmr
        tyag_frame_timer u_tmr (
            .pclk       (pclk),
            .presetn    (presetn),
            .clear      (tmr_clear[i]),
            .frame_tick (frame_tick),
            .limit      (limit),
            .count      (tmr_cnt[i]),
            .done       (tmr_done[i])
        );
    end

    // ===========================================
    // outputs
    assign prdata         = prdata_q;
    assign pready         = pready_q;
    assign pslverr        = pslverr_q;
    assign rai_active     = active_q;
    assign rai_format     = fmt_q;
    assign rai_bit2_force = bit2_q;

    // ===========================================
    // assertions
    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_wait;
        psel && penable && !pready_q;
    endsequence

    property p_apb_answer;
        @(posedge pclk) disable iff (!presetn)
        s_setup ##1 s_wait |=> pready_q;
    endproperty
    a_apb_answer: assert property (p_apb_answer)
        else $error("apb answer not after one wait");

    property p_rule_write;
        @(posedge pclk) disable iff (!presetn)
        wr_agc |=> rule_en == $past(pwdata[7]);
    endproperty
    a_rule_write: assert property (p_rule_write)
        else $error("rule bit not written");

    property p_min_time;
        @(posedge pclk) disable iff (!presetn)
        $fell(active_q) |-> $past(tmr_cnt[0]) >= limit;
    endproperty
    a_min_time: assert property (p_min_time)
        else $error("alarm shorter than one second");

    property p_gap_hold;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ST_GAP) && rule_en && !tmr_done[1]
            |=> !active_q;
    endproperty
    a_gap_hold: assert property (p_gap_hold)
        else $error("alarm restarted inside gap");

    property p_req_start;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ST_IDLE) && rule_en && req && fmt_on
            |=> active_q && fmt_q == $past(fmt_sel);
    endproperty
    a_req_start: assert property (p_req_start)
        else $error("request did not start alarm");

    property p_req_hold;
        @(posedge pclk) disable iff (!presetn)
        active_q && rule_en && req && fmt_on |=> active_q;
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("alarm stopped while requested");

    property p_no_gap;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ST_SEND) && !rule_en && !fmt_on &&
            tmr_done[0] |=> state_q == ST_IDLE ##1
            ($past(rule_en) || !$past(fmt_on) || active_q);
    endproperty
    a_no_gap: assert property (p_no_gap)
        else $error("gap imposed without rule");

    property p_ignore_req;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ST_IDLE) && !rule_en
            |=> active_q == $past(fmt_on);
    endproperty
    a_ignore_req: assert property (p_ignore_req)
        else $error("request bit not ignored");

    property p_bit2;
        @(posedge pclk) disable iff (!presetn)
        rai_bit2_force |-> active_q && fmt_q == FMT_BIT2 &&
            is_bit2_framing($past(ffs_q));
    endproperty
    a_bit2: assert property (p_bit2)
        else $error("bit two forced wrongly");

    property p_tmr_clear;
        @(posedge pclk) disable iff (!presetn)
        $rose(active_q) |-> tmr_cnt[0] == '0;
    endproperty
    a_tmr_clear: assert property (p_tmr_clear)
        else $error("duration timer not cleared");

    property p_gap_clear;
        @(posedge pclk) disable iff (!presetn)
        $rose(state_q == ST_GAP) |-> tmr_cnt[1] == '0;
    endproperty
    a_gap_clear: assert property (p_gap_clear)
        else $error("gap timer not cleared");

    property p_gap_abort;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ST_GAP) && !rule_en |=> state_q == ST_IDLE;
    endproperty
    a_gap_abort: assert property (p_gap_abort)
        else $error("gap kept without rule");

    property p_send_floor;
        @(posedge pclk) disable iff (!presetn)
        active_q && !tmr_done[0] |=> active_q;
    endproperty
    a_send_floor: assert property (p_send_floor)
        else $error("alarm ended before one second");

    property p_off_idle;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ST_IDLE) && !fmt_on |=> !active_q;
    endproperty
    a_off_idle: assert property (p_off_idle)
        else $error("alarm started with format off");

    property p_fmt_idle;
        @(posedge pclk) disable iff (!presetn)
        !active_q |-> rai_format == FMT_OFF && !rai_bit2_force;
    endproperty
    a_fmt_idle: assert property (p_fmt_idle)
        else $error("format shown while idle");

    // read data must not leak outside the answer cycle
    property p_rd_idle;
        @(posedge pclk) disable iff (!presetn)
        !pready_q |-> prdata_q == 32'h00000000;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside answer");

    property p_err_pair;
        @(posedge pclk) disable iff (!presetn)
        pslverr_q |-> pready_q;
    endproperty
    a_err_pair: assert property (p_err_pair)
        else $error("error without ready");

    property p_drop_write;
        @(posedge pclk) disable iff (!presetn)
        commit && pwrite && !mapped |=> $stable(agc_q) && $stable(ffs_q);
    endproperty
    a_drop_write: assert property (p_drop_write)
        else $error("unmapped write changed a register");
endmodule // tyag_top
`default_nettype wire

/* File: tb/tyag_far_end.sv */
// far-end model: frame pacing and alarm episode timing
`timescale 1ns/1ps
`default_nettype none
// ===========================================
// remote terminal side of the framed line
module tyag_far_end #(
    parameter int DIV = 4
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       rai_active,
    output var  logic       frame_tick,
    output var  logic [7:0] ep_len,
    output var  logic [7:0] gap_len
);
    logic [7:0] div_q;
    logic [7:0] run_q;
    logic       act_q;
    // frames run back to back, the line never idles
    assign frame_tick = (div_q == 8'(DIV - 1));
    // ticks are counted per episode, latched when the alarm level flips
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q   <= 8'h00;
            run_q   <= 8'h00;
            act_q   <= 1'b0;
            ep_len  <= 8'h00;
            gap_len <= 8'h00;
        end else begin
            div_q <= frame_tick ? 8'h00 : div_q + 8'h01;
            act_q <= rai_active;
            if (rai_active == act_q) begin
                run_q <= run_q + {7'h00, frame_tick};
            end else begin
                run_q <= {7'h00, frame_tick};
                if (act_q) begin
                    ep_len <= run_q;
                end else begin
                    gap_len <= run_q;
                end
            end
        end
    end
endmodule // tyag_far_end
`default_nettype wire

/* File: tb/tyag_top_tb_top.sv */
// testbench: apb register access and alarm timing checks
`timescale 1ns/1ps
`default_nettype none
module tyag_top_tb_top;
    import tyag_pkg::*;
    localparam int N = 8;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, er, frame_tick, rai_active, rai_bit2_force;
    logic [1:0]  rai_format;
    logic [7:0]  ep_len, gap_len;
    int          miscompares = 0;
    int          n_tests = 0;
    // ===========================================
    always #5 pclk = ~pclk;
    tyag_top #(.FRAMES_PER_SECOND(N)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .frame_tick(frame_tick), .rai_active(rai_active),
        .rai_format(rai_format), .rai_bit2_force(rai_bit2_force));
    tyag_far_end #(.DIV(4)) far (.pclk(pclk), .presetn(presetn), .rai_active(rai_active),
        .frame_tick(frame_tick), .ep_len(ep_len), .gap_len(gap_len));
    // ===========================================
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one idle cycle first so psel is never assigned twice in one step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready", 32'h1, {31'h0, pready});
    endtask
    // extra edge lets the far end latch its episode count
    task automatic wait_rai(input logic v, input int lim);
        int n;
        n = 0;
        while (rai_active !== v && n < lim) begin
            @(negedge pclk);
            n++;
        end
        @(negedge pclk);
        chk("rai_active", {31'h0, v}, {31'h0, rai_active});
    endtask
    task automatic chk_len();
        chk("episode frames", 32'h1, {31'h0, ep_len >= N && ep_len <= N + 1});
    endtask
    // ===========================================
    task automatic t_regs();
        apb(1'b0, AGC_OFF, 32'h0);
        chk("agc reset", {24'h0, AGC_RST}, rd);
        apb(1'b0, FFS_OFF, 32'h0);
        chk("ffs reset", {29'h0, FFS_RST}, rd);
        apb(1'b0, 12'h00c, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, FFS_OFF, 32'hffff_fffd);
        apb(1'b1, STAT_OFF, 32'hf);
        apb(1'b0, FFS_OFF, 32'h0);
        chk("ffs upper bits", {29'h0, FFS_SF}, rd);
        apb(1'b0, STAT_OFF, 32'h0);
        chk("status read only", 32'h0, rd);
        $display("test regs done");
    endtask
    task automatic t_enf();
        apb(1'b1, AGC_OFF, 32'hd0);
        wait_rai(1'b1, 10);
        chk("format", 32'h1, {30'h0, rai_format});
        chk("bit2 force", 32'h1, {31'h0, rai_bit2_force});
        apb(1'b0, STAT_OFF, 32'h0);
        chk("status", 32'h5, rd);
        repeat (80) @(negedge pclk);
        chk("held by request", 32'h1, {31'h0, rai_active});
        apb(1'b1, AGC_OFF, 32'h90);
        wait_rai(1'b0, 20);
        apb(1'b1, AGC_OFF, 32'he0);
        wait_rai(1'b1, 200);
        chk("gap frames", 32'h1, {31'h0, gap_len >= N});
        chk("format", 32'h2, {30'h0, rai_format});
        chk("bit2 force", 32'h0, {31'h0, rai_bit2_force});
        apb(1'b1, AGC_OFF, 32'ha0);
        wait_rai(1'b0, 200);
        chk_len();
        // clearing the rule drops the pending gap
        apb(1'b1, AGC_OFF, 32'h0);
        $display("test enforced done");
    endtask
    task automatic t_free();
        apb(1'b1, FFS_OFF, 32'h0);
        apb(1'b1, AGC_OFF, 32'h10);
        wait_rai(1'b1, 10);
        chk("format", 32'h1, {30'h0, rai_format});
        chk("bit2 force esf", 32'h0, {31'h0, rai_bit2_force});
        apb(1'b1, FFS_OFF, {29'h0, FFS_N});
        repeat (2) @(negedge pclk);
        chk("bit2 force n", 32'h1, {31'h0, rai_bit2_force});
        apb(1'b1, AGC_OFF, 32'h0);
        wait_rai(1'b0, 200);
        chk_len();
        apb(1'b1, AGC_OFF, 32'h20);
        wait_rai(1'b1, 20);
        chk("short gap", 32'h1, {31'h0, gap_len < N});
        chk("format", 32'h2, {30'h0, rai_format});
        apb(1'b1, AGC_OFF, 32'h40);
        wait_rai(1'b0, 200);
        repeat (100) @(negedge pclk);
        chk("request ignored", 32'h0, {31'h0, rai_active});
        apb(1'b1, AGC_OFF, 32'hc0);
        repeat (100) @(negedge pclk);
        chk("format off", 32'h0, {31'h0, rai_active});
        $display("test free done");
    endtask
    // ===========================================
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // whole run is a few hundred cycles; this is far beyond it
    initial begin
        #100us;
        miscompares++;
        give_verdict();
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_enf();
        t_free();
        give_verdict();
    end
endmodule // tyag_top_tb_top
`default_nettype wire
